// *** adc_seq_pkg.sv ***
// Constants shared by the sample/convert sequencer and its testbench.
// Assumes one 250 MHz clock and APB register access with 32-bit data.
//
// Overview of operation
// [R1] Trigger codes 1111 to 1101 and 0100 to 0010 are reserved and never end sampling.
// [R2] Code 1100 ends sampling on a logic cell two event, code 1011 on a logic cell one event.
// [R3] Codes 1010, 1001 and 1000 end sampling on capture unit three, two and one events.
// [R4] Code 0111 lets an internal counter end sampling with no outside event.
// [R5] Codes 0110 and 0101 end sampling on a timer period match, only 0110 while asleep.
// [R6] Code 0001 ends sampling on an active edge of external interrupt pin zero.
// [R7] Code 0000 ends sampling when software clears the sample control bit.
// [R8] Resolution select at bit 3 gives 12-bit conversion when set, 10-bit when clear.
// [R9] With auto sample start at bit 2 set, a new sample starts right after each conversion.
// [R10] With auto sample start clear, sampling waits for software to set sample control.
// [R11] Sample control at bit 1 reads 1 while sampling and 0 while holding.
// [R12] The done bit at position 0 reads 1 once a conversion has completed.
// [R13] Clearing the done bit by software leaves any sample or conversion running.
// [R14] While the converter is disabled, sample control stays 0 and writes to it are ignored.
// [R15] In automatic operation the done bit is cleared when the next sample starts.
// [R16] The external pin is synchronised and edge detected into a one-cycle pulse.
// [R17] Done is set the cycle after end of conversion; a trigger clears sample control.
package adc_seq_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int RESULT_W = 12;
   localparam int IRQ_W = 2;
   localparam int SAMPLE_TIME_W = 8;
   localparam int EVENT_W = 6;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_SAMPLE_TIME = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h10;

   // Control register fields
   localparam int CTL_DONE_BIT = 0;
   localparam int CTL_SAMPLE_BIT = 1;
   localparam int CTL_AUTO_BIT = 2;
   localparam int CTL_RES_BIT = 3;
   localparam int CTL_TRIG_LSB = 4;
   localparam int CTL_TRIG_MSB = 7;
   localparam int CTL_ENABLE_BIT = 15;

   // Interrupt status and mask fields
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_SAMPLE_END_BIT = 1;

   // Trigger source codes
   localparam logic [3:0] TRIG_MANUAL = 4'h0;
   localparam logic [3:0] TRIG_EXT_PIN = 4'h1;
   localparam logic [3:0] TRIG_TIMER_AWAKE = 4'h5;
   localparam logic [3:0] TRIG_TIMER_SLEEP = 4'h6;
   localparam logic [3:0] TRIG_AUTO_CONVERT = 4'h7;
   localparam logic [3:0] TRIG_CAPTURE_ONE = 4'h8;
   localparam logic [3:0] TRIG_CAPTURE_TWO = 4'h9;
   localparam logic [3:0] TRIG_CAPTURE_THREE = 4'hA;
   localparam logic [3:0] TRIG_CELL_ONE = 4'hB;
   localparam logic [3:0] TRIG_CELL_TWO = 4'hC;

   // Event vector positions
   localparam int EV_CELL_ONE = 0;
   localparam int EV_CELL_TWO = 1;
   localparam int EV_CAPTURE_ONE = 2;
   localparam int EV_CAPTURE_TWO = 3;
   localparam int EV_CAPTURE_THREE = 4;
   localparam int EV_TIMER = 5;

   // Reset values
   localparam logic [SAMPLE_TIME_W-1:0] SAMPLE_TIME_RESET = 8'h0F;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_CONVERT
   } seq_state_e;

endpackage

// *** adc_sample_convert_sequencer.sv ***
// Sample/convert sequencer for the converter control register, with
// interrupt status, mask, auto-convert sample time and result registers.
// Assumes on-chip event inputs are synchronous to pclk; the external
// interrupt pin is not, and is synchronised here.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module adc_sample_convert_sequencer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adc_seq_pkg::ADDR_W-1:0] paddr,
   input wire logic [adc_seq_pkg::DATA_W-1:0] pwdata,
   output logic [adc_seq_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic logic_cell_one_event,
   input wire logic logic_cell_two_event,
   input wire logic capture_unit_one_event,
   input wire logic capture_unit_two_event,
   input wire logic capture_unit_three_event,
   input wire logic general_timer_one_match,
   input wire logic ext_int_zero_pin,
   input wire logic device_sleep,
   output logic conv_start,
   output logic conv_sampling,
   output logic conv_twelve_bit,
   input wire logic conv_end,
   input wire logic [adc_seq_pkg::RESULT_W-1:0] conv_data,
   output logic irq
);

   function automatic logic is_reserved_code(input logic [3:0] code);
      is_reserved_code = (code >= 4'hD) || (code >= 4'h2 && code <= 4'h4);
   endfunction

   function automatic logic select_trigger(
      input logic [3:0] code,
      input logic [adc_seq_pkg::EVENT_W-1:0] ev,
      input logic pin_edge,
      input logic asleep,
      input logic count_hit,
      input logic sw_clear
   );
      case (code)
         adc_seq_pkg::TRIG_CELL_TWO: select_trigger =
            ev[adc_seq_pkg::EV_CELL_TWO];
         adc_seq_pkg::TRIG_CELL_ONE: select_trigger =
            ev[adc_seq_pkg::EV_CELL_ONE];
         adc_seq_pkg::TRIG_CAPTURE_THREE: select_trigger =
            ev[adc_seq_pkg::EV_CAPTURE_THREE];
         adc_seq_pkg::TRIG_CAPTURE_TWO: select_trigger =
            ev[adc_seq_pkg::EV_CAPTURE_TWO];
         adc_seq_pkg::TRIG_CAPTURE_ONE: select_trigger =
            ev[adc_seq_pkg::EV_CAPTURE_ONE];
         adc_seq_pkg::TRIG_AUTO_CONVERT: select_trigger = count_hit;
         adc_seq_pkg::TRIG_TIMER_SLEEP: select_trigger =
            ev[adc_seq_pkg::EV_TIMER];
         adc_seq_pkg::TRIG_TIMER_AWAKE: select_trigger =
            ev[adc_seq_pkg::EV_TIMER] && !asleep;
         adc_seq_pkg::TRIG_EXT_PIN: select_trigger = pin_edge;
         adc_seq_pkg::TRIG_MANUAL: select_trigger = sw_clear;
         default: select_trigger = 1'b0;
      endcase
   endfunction

   adc_seq_pkg::seq_state_e state_reg, state_next;
   logic enable_reg;
   logic [3:0] trig_sel_reg;
   logic res_sel_reg;
   logic auto_start_reg;
   logic sample_control_reg, sample_control_next;
   logic done_reg, done_next;
   logic start_reg, start_next;
   logic [adc_seq_pkg::SAMPLE_TIME_W-1:0] count_reg, count_next;
   logic [adc_seq_pkg::SAMPLE_TIME_W-1:0] sample_time_reg;
   logic [adc_seq_pkg::RESULT_W-1:0] result_reg;
   logic [adc_seq_pkg::IRQ_W-1:0] irq_status_reg, irq_status_next;
   logic [adc_seq_pkg::IRQ_W-1:0] irq_mask_reg;
   logic [adc_seq_pkg::IRQ_W-1:0] irq_set;
   logic [adc_seq_pkg::EVENT_W-1:0] event_prev_reg;
   logic ext_meta_reg, ext_sync_reg, ext_prev_reg;
   logic [adc_seq_pkg::DATA_W-1:0] prdata_reg;
   logic pslverr_reg;
   logic sample_end;

   // Bus decode
   wire bus_setup = psel && !penable;
   wire bus_write = psel && penable && pwrite;
   wire hit_control = (paddr == adc_seq_pkg::OFF_CONTROL);
   wire hit_status = (paddr == adc_seq_pkg::OFF_IRQ_STATUS);
   wire hit_mask = (paddr == adc_seq_pkg::OFF_IRQ_MASK);
   wire hit_time = (paddr == adc_seq_pkg::OFF_SAMPLE_TIME);
   wire hit_result = (paddr == adc_seq_pkg::OFF_RESULT);
   wire addr_hit = hit_control || hit_status || hit_mask || hit_time ||
      hit_result;
   wire wr_control = bus_write && hit_control;
   wire wr_status = bus_write && hit_status;
   wire wr_mask = bus_write && hit_mask;
   wire wr_time = bus_write && hit_time;

   wire enable_next = wr_control ? pwdata[adc_seq_pkg::CTL_ENABLE_BIT]
      : enable_reg;
   // Sample bit writes only count while enabled
   wire sw_sample_control_set = wr_control && enable_next && // R14
      pwdata[adc_seq_pkg::CTL_SAMPLE_BIT];
   wire sw_sample_control_clear = wr_control && enable_next &&
      !pwdata[adc_seq_pkg::CTL_SAMPLE_BIT];
   wire sw_done_clear = wr_control && !pwdata[adc_seq_pkg::CTL_DONE_BIT];

   // Rising edges of on-chip event lines, so a held level fires once
   wire [adc_seq_pkg::EVENT_W-1:0] event_now = {general_timer_one_match,
      capture_unit_three_event, capture_unit_two_event,
      capture_unit_one_event, logic_cell_two_event, logic_cell_one_event};
   wire [adc_seq_pkg::EVENT_W-1:0] event_rise = event_now & ~event_prev_reg;
   wire pin_edge = ext_sync_reg && !ext_prev_reg; // R16

   wire count_hit = (count_reg >= sample_time_reg); // R4
   wire end_sampling = select_trigger(trig_sel_reg, event_rise, pin_edge,
      device_sleep, count_hit, sw_sample_control_clear); // R1 R2 R3 R5 R6 R7
   wire conv_finish = (state_reg == adc_seq_pkg::ST_CONVERT) && conv_end;

   // Ten-bit results keep the low bits only
   wire [adc_seq_pkg::RESULT_W-1:0] result_masked = res_sel_reg ?
      conv_data : {2'b00, conv_data[9:0]}; // R8

   always_comb begin
      state_next = state_reg;
      sample_control_next = sample_control_reg;
      done_next = done_reg;
      count_next = count_reg;
      start_next = 1'b0;
      sample_end = 1'b0;
      // Software clear touches only the flag, never the sequence
      if (sw_done_clear) begin
         done_next = 1'b0; // R13
      end
      if (!enable_next) begin
         state_next = adc_seq_pkg::ST_IDLE;
         sample_control_next = 1'b0; // R14
         count_next = '0;
         if (conv_finish) begin
            done_next = 1'b1;
         end
      end else begin
         case (state_reg)
            adc_seq_pkg::ST_IDLE: begin
               if (auto_start_reg) begin
                  state_next = adc_seq_pkg::ST_SAMPLE; // R9
                  sample_control_next = 1'b1;
                  done_next = 1'b0; // R15
                  count_next = '0;
               end else if (sw_sample_control_set) begin
                  state_next = adc_seq_pkg::ST_SAMPLE; // R10
                  sample_control_next = 1'b1;
                  count_next = '0;
               end
            end
            adc_seq_pkg::ST_SAMPLE: begin
               if (end_sampling) begin
                  state_next = adc_seq_pkg::ST_CONVERT;
                  sample_control_next = 1'b0; // R17
                  start_next = 1'b1;
                  sample_end = 1'b1;
               end else if (count_reg != '1) begin
                  count_next = count_reg + 1'b1;
               end
            end
            adc_seq_pkg::ST_CONVERT: begin
               if (conv_end) begin
                  state_next = adc_seq_pkg::ST_IDLE;
                  done_next = 1'b1; // R12 R17
               end
            end
            default: begin
               state_next = adc_seq_pkg::ST_IDLE;
               sample_control_next = 1'b0;
            end
         endcase
      end
   end

   // Status bits: hardware set wins over a write-one clear
   assign irq_set = {sample_end, conv_finish};
   assign irq_status_next = (irq_status_reg &
      ~(wr_status ? pwdata[adc_seq_pkg::IRQ_W-1:0] : '0)) | irq_set;

   wire [adc_seq_pkg::DATA_W-1:0] control_read = {16'h0000, enable_reg,
      7'h00, trig_sel_reg, res_sel_reg, auto_start_reg, sample_control_reg,
      done_reg}; // R11 R12
   wire [adc_seq_pkg::DATA_W-1:0] read_mux =
      hit_control ? control_read :
      hit_status ? {30'h0000_0000, irq_status_reg} :
      hit_mask ? {30'h0000_0000, irq_mask_reg} :
      hit_time ? {24'h00_0000, sample_time_reg} :
      hit_result ? {20'h0_0000, result_reg} :
      adc_seq_pkg::READ_ZERO;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_meta_reg <= 1'b0;
         ext_sync_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
         event_prev_reg <= '0;
      end else begin
         ext_meta_reg <= ext_int_zero_pin; // R16
         ext_sync_reg <= ext_meta_reg;
         ext_prev_reg <= ext_sync_reg;
         event_prev_reg <= event_now;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_reg <= 1'b0;
         trig_sel_reg <= adc_seq_pkg::TRIG_MANUAL;
         res_sel_reg <= 1'b0;
         auto_start_reg <= 1'b0;
      end else if (wr_control) begin
         enable_reg <= pwdata[adc_seq_pkg::CTL_ENABLE_BIT];
         trig_sel_reg <=
            pwdata[adc_seq_pkg::CTL_TRIG_MSB:adc_seq_pkg::CTL_TRIG_LSB];
         res_sel_reg <= pwdata[adc_seq_pkg::CTL_RES_BIT]; // R8
         auto_start_reg <= pwdata[adc_seq_pkg::CTL_AUTO_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= adc_seq_pkg::ST_IDLE;
         sample_control_reg <= 1'b0;
         done_reg <= 1'b0;
         start_reg <= 1'b0;
         count_reg <= '0;
      end else begin
         state_reg <= state_next;
         sample_control_reg <= sample_control_next;
         done_reg <= done_next;
         start_reg <= start_next;
         count_reg <= count_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= '0;
         irq_mask_reg <= '0;
         sample_time_reg <= adc_seq_pkg::SAMPLE_TIME_RESET;
         result_reg <= '0;
      end else begin
         irq_status_reg <= irq_status_next;
         if (wr_mask) begin
            irq_mask_reg <= pwdata[adc_seq_pkg::IRQ_W-1:0];
         end
         if (wr_time) begin
            sample_time_reg <= pwdata[adc_seq_pkg::SAMPLE_TIME_W-1:0];
         end
         if (conv_finish) begin
            result_reg <= result_masked;
         end
      end
   end

   // Read data is latched in the setup cycle so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= adc_seq_pkg::READ_ZERO;
         pslverr_reg <= 1'b0;
      end else if (bus_setup) begin
         prdata_reg <= pwrite ? adc_seq_pkg::READ_ZERO : read_mux;
         pslverr_reg <= !addr_hit;
      end
   end

   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg && psel && penable;
   assign pready = psel && penable;
   assign conv_start = start_reg;
   assign conv_sampling = sample_control_reg; // R11
   assign conv_twelve_bit = res_sel_reg; // R8
   assign irq = |(irq_status_reg & irq_mask_reg);

   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   wire sampling_steady = (state_reg == adc_seq_pkg::ST_SAMPLE) &&
      enable_reg && !wr_control;

   AST_RESERVED_HOLDS: assert property ( // R1
      sampling_steady && is_reserved_code(trig_sel_reg)
      |=> conv_sampling && !conv_start)
      else $error("reserved trigger code ended sampling");

   AST_CELL_TRIGGER: assert property ( // R2
      sampling_steady && ((trig_sel_reg == adc_seq_pkg::TRIG_CELL_TWO &&
      event_rise[adc_seq_pkg::EV_CELL_TWO]) ||
      (trig_sel_reg == adc_seq_pkg::TRIG_CELL_ONE &&
      event_rise[adc_seq_pkg::EV_CELL_ONE]))
      |=> conv_start && !conv_sampling)
      else $error("logic cell event did not start conversion");

   AST_CAPTURE_TRIGGER: assert property ( // R3
      sampling_steady && ((trig_sel_reg == adc_seq_pkg::TRIG_CAPTURE_ONE &&
      event_rise[adc_seq_pkg::EV_CAPTURE_ONE]) ||
      (trig_sel_reg == adc_seq_pkg::TRIG_CAPTURE_TWO &&
      event_rise[adc_seq_pkg::EV_CAPTURE_TWO]) ||
      (trig_sel_reg == adc_seq_pkg::TRIG_CAPTURE_THREE &&
      event_rise[adc_seq_pkg::EV_CAPTURE_THREE]))
      |=> conv_start && !conv_sampling)
      else $error("capture event did not start conversion");

   AST_AUTO_CONVERT_TIME: assert property ( // R4
      sampling_steady && trig_sel_reg == adc_seq_pkg::TRIG_AUTO_CONVERT &&
      count_reg == sample_time_reg |=> conv_start)
      else $error("auto convert did not end sampling on count");

   AST_TIMER_SLEEP_GATE: assert property ( // R5
      sampling_steady && trig_sel_reg == adc_seq_pkg::TRIG_TIMER_AWAKE &&
      device_sleep |=> !conv_start)
      else $error("timer code 0101 triggered during sleep");

   AST_PIN_TRIGGER: assert property ( // R6
      sampling_steady && trig_sel_reg == adc_seq_pkg::TRIG_EXT_PIN &&
      $rose(ext_sync_reg) |=> conv_start)
      else $error("pin edge did not start conversion");

   AST_MANUAL_CLEAR: assert property ( // R7
      (state_reg == adc_seq_pkg::ST_SAMPLE) &&
      trig_sel_reg == adc_seq_pkg::TRIG_MANUAL && sw_sample_control_clear
      |=> conv_start && !conv_sampling)
      else $error("software clear did not start conversion");

   AST_AUTO_RESTART: assert property ( // R9
      conv_finish && enable_reg && auto_start_reg && !wr_control
      |=> done_reg && !conv_sampling ##1 conv_sampling && !done_reg)
      else $error("auto start did not resample after conversion");

   AST_MANUAL_WAIT: assert property ( // R10
      (state_reg == adc_seq_pkg::ST_IDLE) && !auto_start_reg &&
      !sw_sample_control_set |=> !conv_sampling)
      else $error("sampling started without software");

   AST_DONE_AFTER_END: assert property ( // R17
      conv_finish |=> done_reg && !conv_sampling)
      else $error("done not set the cycle after end of conversion");

   AST_DISABLED_IDLE: assert property ( // R14
      !enable_reg |-> !sample_control_reg && state_reg == adc_seq_pkg::ST_IDLE)
      else $error("sample control set while disabled");

   AST_DONE_CLEAR_SAFE: assert property ( // R13
      sw_done_clear && enable_next &&
      state_reg == adc_seq_pkg::ST_CONVERT && !conv_end
      |=> state_reg == adc_seq_pkg::ST_CONVERT)
      else $error("done clear disturbed a running conversion");

   AST_AUTO_DONE_CLEAR: assert property ( // R15
      state_reg == adc_seq_pkg::ST_IDLE && enable_reg && auto_start_reg &&
      !wr_control |=> conv_sampling && !done_reg)
      else $error("done not cleared at auto sample start");

   AST_TEN_BIT_RESULT: assert property ( // R8
      conv_finish && !res_sel_reg |=> result_reg[11:10] == 2'b00)
      else $error("ten bit result kept upper bits");

   COV_MANUAL: cover property (
      trig_sel_reg == adc_seq_pkg::TRIG_MANUAL && conv_finish);
   COV_AUTO_LOOP: cover property (
      conv_finish && auto_start_reg ##2 conv_sampling);
   COV_PIN: cover property (
      trig_sel_reg == adc_seq_pkg::TRIG_EXT_PIN && conv_start);
   COV_IRQ: cover property ($rose(irq));
   COV_RESERVED: cover property (
      sampling_steady && is_reserved_code(trig_sel_reg));

endmodule

// *** adc_core_model.sv ***
// Behavioural converter core facing the sequencer's conversion port.
// Assumes conv_start is a one-cycle pulse synchronous to pclk.
`timescale 1ns/10ps
module adc_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic conv_start,
   input wire logic slow,
   input wire logic [adc_seq_pkg::RESULT_W-1:0] sample_value,
   output logic conv_end,
   output logic [adc_seq_pkg::RESULT_W-1:0] conv_data
);
   logic [5:0] count_reg;
   logic busy_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg <= 1'b0;
         count_reg <= 6'h00;
         conv_end <= 1'b0;
         conv_data <= 12'h000;
      end else begin
         conv_end <= 1'b0;
         // Data only valid with the end pulse, so toggle it otherwise
         conv_data <= ~conv_data;
         if (conv_start) begin
            busy_reg <= 1'b1;
            count_reg <= slow ? 6'h14 : 6'h03;
         end else if (busy_reg) begin
            if (count_reg == 6'h00) begin
               busy_reg <= 1'b0;
               conv_end <= 1'b1;
               conv_data <= sample_value;
            end else begin
               count_reg <= count_reg - 6'h01;
            end
         end
      end
   end
endmodule

// *** tb_adc_sample_convert_sequencer.sv ***
// Self-checking bench for the sample/convert sequencer.
// Assumes APB at offsets of adc_seq_pkg and the core model beside it.
`timescale 1ns/10ps
module tb_adc_sample_convert_sequencer;
   typedef struct {
      string name;
      logic [31:0] mask;
      logic [31:0] exp;
      logic err;
   } note_s;
   localparam logic [7:0] A_CTL = adc_seq_pkg::OFF_CONTROL;
   localparam logic [7:0] A_ST = adc_seq_pkg::OFF_IRQ_STATUS;
   localparam logic [7:0] A_MSK = adc_seq_pkg::OFF_IRQ_MASK;
   localparam logic [31:0] M_S = 32'h0000_0002;
   localparam logic [31:0] M_D = 32'h0000_0001;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, conv_start, conv_sampling, conv_twelve_bit;
   logic conv_end, irq;
   logic [11:0] conv_data;
   logic [11:0] sv = 12'h000;
   logic [6:0] ev = 7'h00;
   logic device_sleep = 1'b0;
   logic slow = 1'b0;
   note_s q[$];
   int err_count = 0;
   int compares = 0;
   int starts = 0;

   always #2 pclk = ~pclk;

   adc_sample_convert_sequencer adc_sample_convert_sequencer_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .logic_cell_one_event(ev[0]), .logic_cell_two_event(ev[1]),
      .capture_unit_one_event(ev[2]), .capture_unit_two_event(ev[3]),
      .capture_unit_three_event(ev[4]), .general_timer_one_match(ev[5]),
      .ext_int_zero_pin(ev[6]), .device_sleep(device_sleep),
      .conv_start(conv_start), .conv_sampling(conv_sampling),
      .conv_twelve_bit(conv_twelve_bit), .conv_end(conv_end),
      .conv_data(conv_data), .irq(irq));

   adc_core_model adc_core_model_i (
      .pclk(pclk), .presetn(presetn), .conv_start(conv_start),
      .slow(slow), .sample_value(sv), .conv_end(conv_end),
      .conv_data(conv_data));

   always @(posedge pclk) begin
      if (conv_start === 1'b1) starts++;
   end

   // Read results are judged where they appear on the bus
   always @(posedge pclk) begin : mon
      note_s n;
      if (psel && penable && pready && !pwrite) begin
         compares++;
         if (q.size() == 0) begin
            err_count++;
            $display("[ERR] read_queue expected note got none");
         end else begin
            n = q.pop_front();
            if ((prdata & n.mask) !== n.exp || pslverr !== n.err) begin
               err_count++;
               $display("[ERR] %s expected %h/%b got %h/%b", n.name,
                  n.exp, n.err, prdata, pslverr);
            end
         end
      end
   end

   task automatic tally_and_finish();
      if (q.size() != 0) begin
         err_count++;
         $display("[ERR] read_queue expected 0 got %0d", q.size());
      end
      if (err_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h got %h", nm, e, g);
      end
   endtask

   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a stuck wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(string nm, logic [7:0] a, logic [31:0] m,
                     logic [31:0] e, logic er = 1'b0);
      q.push_back('{nm, m, e, er});
      apb(1'b0, a, 32'h0000_0000);
   endtask

   function automatic logic [31:0] ctl(logic en, logic [3:0] c, logic r,
                                       logic au, logic s);
      ctl = 32'h0000_0000;
      ctl[adc_seq_pkg::CTL_ENABLE_BIT] = en;
      ctl[adc_seq_pkg::CTL_TRIG_MSB:adc_seq_pkg::CTL_TRIG_LSB] = c;
      ctl[adc_seq_pkg::CTL_RES_BIT] = r;
      ctl[adc_seq_pkg::CTL_AUTO_BIT] = au;
      ctl[adc_seq_pkg::CTL_SAMPLE_BIT] = s;
   endfunction

   function automatic logic [6:0] evmask(logic [3:0] c);
      case (c)
         4'hB: evmask = 7'h01;
         4'hC: evmask = 7'h02;
         4'h8: evmask = 7'h04;
         4'h9: evmask = 7'h08;
         4'hA: evmask = 7'h10;
         4'h5, 4'h6: evmask = 7'h20;
         4'h1: evmask = 7'h40;
         default: evmask = 7'h7F;
      endcase
   endfunction

   task automatic wait_end();
      int i;
      for (i = 0; i < 100 && conv_end !== 1'b1; i++) @(posedge pclk);
      chk("conv_end_seen", 1, (i < 100));
   endtask

   task automatic run_code(logic [3:0] c, logic slp, logic hit);
      int n0;
      device_sleep <= slp;
      slow <= 1'($urandom_range(0, 1));
      sv <= 12'($urandom);
      apb(1'b1, A_CTL, ctl(1'b1, c, 1'b1, 1'b0, 1'b1));
      n0 = starts;
      // Long pulse: a single event must still give one conversion
      ev <= evmask(c);
      repeat (4) @(posedge pclk);
      chk("twelve_bit_on", 1, conv_twelve_bit);
      ev <= 7'h00;
      repeat (30) @(posedge pclk);
      chk("start_count", hit, starts - n0);
      rd("ctl_state", A_CTL, M_S | M_D, hit ? M_D : M_S);
      if (hit) rd("result", 8'h10, 32'h0000_0FFF, {20'h0_0000, sv});
      apb(1'b1, A_CTL, 32'h0000_0000);
      device_sleep <= 1'b0;
   endtask

   initial begin
      #80000;
      err_count++;
      $display("[ERR] watchdog expected finish got timeout");
      tally_and_finish();
   end

   initial begin : main
      int st, n;
      void'($urandom(98779));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd("ctl_reset", A_CTL, 32'hFFFF_FFFF, 32'h0000_0000);
      rd("time_reset", 8'h0C, 32'hFFFF_FFFF, 32'h0000_000F);
      rd("unmapped", 8'h14, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
      apb(1'b1, A_CTL, ctl(1'b0, 4'h0, 1'b0, 1'b0, 1'b1));
      rd("sample_control_disabled", A_CTL, M_S, 32'h0000_0000);
      sv <= 12'($urandom);
      apb(1'b1, A_CTL, ctl(1'b1, 4'h0, 1'b0, 1'b0, 1'b1));
      rd("ctl_sampling", A_CTL, 32'hFFFF_FFFF, ctl(1, 0, 0, 0, 1));
      chk("twelve_bit", 0, conv_twelve_bit);
      apb(1'b1, A_CTL, ctl(1'b1, 4'h0, 1'b0, 1'b0, 1'b0));
      wait_end();
      rd("ctl_done", A_CTL, 32'hFFFF_FFFF, ctl(1, 0, 0, 0, 0) | M_D);
      rd("result10", 8'h10, 32'hFFFF_FFFF, {22'h00_0000, sv[9:0]});
      rd("status", A_ST, 32'hFFFF_FFFF, 32'h0000_0003);
      apb(1'b1, A_MSK, 32'h0000_0001);
      @(posedge pclk);
      chk("irq_on", 1, irq);
      apb(1'b1, A_MSK, 32'h0000_0000);
      @(posedge pclk);
      chk("irq_masked", 0, irq);
      apb(1'b1, A_ST, 32'h0000_0001);
      rd("status_w1c", A_ST, 32'hFFFF_FFFF, 32'h0000_0002);
      apb(1'b1, A_ST, 32'h0000_0002);
      apb(1'b1, A_MSK, 32'h0000_0003);
      @(posedge pclk);
      chk("irq_clear", 0, irq);
      apb(1'b1, A_CTL, 32'h0000_0000);
      for (int c = 1; c < 16; c++)
         if (c != 7) run_code(4'(c), 1'b0, !(c inside {[2:4], [13:15]}));
      run_code(4'h5, 1'b1, 1'b0);
      run_code(4'h6, 1'b1, 1'b1);
      st = $urandom_range(3, 12);
      slow <= 1'b1;
      apb(1'b1, 8'h0C, 32'(st));
      apb(1'b1, A_CTL, ctl(1'b1, 4'h7, 1'b1, 1'b1, 1'b1));
      wait_end();
      repeat (2) @(posedge pclk);
      chk("auto_restart", 1, conv_sampling);
      n = 0;
      while (conv_sampling === 1'b1 && n < 300) begin
         n++;
         @(posedge pclk);
      end
      chk("sample_cycles", st + 1, n);
      rd("done_cleared", A_CTL, M_D, 32'h0000_0000);
      apb(1'b1, A_CTL, ctl(1'b1, 4'h7, 1'b1, 1'b1, 1'b0));
      wait_end();
      apb(1'b1, A_CTL, 32'h0000_0000);
      repeat (4) @(posedge pclk);
      tally_and_finish();
   end
endmodule
